// File: inc/pcg_pkg.sv
// Package: constants for the clock generation and selection block
package pcg_pkg;
	// Wishbone register byte addresses
	localparam logic [7:0] ADDR_DIV_CFG = 8'h00;
	localparam logic [7:0] ADDR_DLY_CFG = 8'h04;
	localparam logic [7:0] ADDR_PHS_CFG = 8'h08;
	localparam logic [7:0] ADDR_SEL_CFG = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h1C;
	localparam logic [7:0] ADDR_LOCK_TIME = 8'h20;
	// Field positions of the divider register
	localparam int DIV_IN_LSB = 0;
	localparam int DIV_FB_LSB = 8;
	localparam int DIV_POST_LSB = 16;
	localparam int DIV_SEC_LSB = 24;
	localparam int DIV_W = 8;
	// Delay register fields
	localparam int DLY_VAL_LSB = 0;
	localparam int DLY_W = 4;
	localparam int DLY_PATH_BIT = 8;
	localparam int DLY_DYN_BIT = 9;
	localparam int FB_SRC_BIT = 10;
	// Phase register fields
	localparam int PHS_LSB = 0;
	localparam int DUTY_LSB = 8;
	localparam int PHS_W = 8;
	// Status bit positions
	localparam int ST_LOCK_BIT = 0;
	localparam int ST_LOCK_CHG_BIT = 1;
	// Interrupt event bit positions
	localparam int EV_LOCK_GAIN = 0;
	localparam int EV_LOCK_LOSS = 1;
	localparam int EV_W = 2;
	// Reset values
	localparam logic [31:0] DIV_CFG_RST = 32'h00010101;
	localparam logic [31:0] DLY_CFG_RST = 32'h00000000;
	localparam logic [31:0] PHS_CFG_RST = 32'h00000100;
	localparam logic [31:0] LOCK_TIME_RST = 32'h00000040;
	// Reference considered absent after this many system clocks
	localparam int REF_TIMEOUT = 64;
	// Clock network shape
	localparam int NUM_QUAD = 4;
	localparam int NUM_LINES = 8;
	localparam int NUM_SRC = 8;
	localparam int SRC_W = 3;
	typedef enum {LK_IDLE, LK_COUNT, LK_LOCKED} pcg_lock_e;
endpackage : pcg_pkg

// File: testbench/pcg_clock_gen_chk.sv
// Checker: port-level properties of the clock generation block
`timescale 1ns/10ps
`default_nettype none
module pcg_clock_gen_chk
	import pcg_pkg::*;
#(
	parameter int DIV_WIDTH = DIV_W
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Clocks and status
	input wire logic refClockIn,
	input wire logic pllLock,
	input wire logic [NUM_QUAD*NUM_LINES-1:0] quadLines,
	input wire logic irq
);
	logic [7:0] idleCnt_r;
	logic refPrev_r;
	logic wbWr;
	assign wbWr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	// Counts clocks since the raw reference pin last moved
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			idleCnt_r <= 8'h00;
			refPrev_r <= 1'b0;
		end else begin
			refPrev_r <= refClockIn;
			if (refClockIn != refPrev_r)
				idleCnt_r <= 8'h00;
			else if (idleCnt_r != 8'hFF)
				idleCnt_r <= idleCnt_r + 8'h01;
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_ack_answer: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not acknowledged");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_unmapped_zero: assert property (
		wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i == 8'h24
		|-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_quad_same: assert property (
		quadLines[5:0] == quadLines[13:8] && quadLines[5:0] == quadLines[21:16]
		&& quadLines[5:0] == quadLines[29:24])
		else $error("quadrant muxes differ");
	a_lock_needs_ref: assert property (
		idleCnt_r > 8'(REF_TIMEOUT + 8) |-> !pllLock)
		else $error("lock held without reference");
	a_dyn_drop: assert property (
		wbWr && wb_adr_i == ADDR_DLY_CFG && wb_sel_i[1]
		&& wb_dat_i[DLY_DYN_BIT] |-> ##[1:4] !pllLock)
		else $error("lock kept after dynamic change");
	a_relock_wait: assert property ($fell(pllLock) |=> !pllLock [*8])
		else $error("lock returned too soon");
	a_irq_masked: assert property (
		wbWr && wb_adr_i == ADDR_IRQ_EN && wb_sel_i[0]
		&& wb_dat_i[1:0] == 2'b00 |-> ##[1:2] !irq)
		else $error("irq high with all enables off");
	c_lock: cover property ($rose(pllLock));
	c_unlock: cover property ($fell(pllLock));
	c_irq: cover property ($rose(irq));
endmodule : pcg_clock_gen_chk

bind pcg_clock_gen pcg_clock_gen_chk #(.DIV_WIDTH(DIV_WIDTH)) u_chk (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.refClockIn(refClockIn),
	.pllLock(pllLock),
	.quadLines(quadLines),
	.irq(irq)
);
`default_nettype wire

// File: testbench/pcg_fabric_model.sv
// Partner: fabric logic that sources the reference and consumes the clocks
`timescale 1ns/10ps
`default_nettype none
module pcg_fabric_model #(
	parameter int HALF = 4
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Bench control
	input wire logic refRun,
	input wire logic cntClr,
	// Clocks
	input wire logic primaryPllOut,
	input wire logic dividedPllOut,
	output logic refClockIn,
	output logic userFeedbackIn,
	// Rising edge counts
	output logic [15:0] primCnt,
	output logic [15:0] divCnt
);
	logic [7:0] phase_r;
	logic primPrev_r;
	logic divPrev_r;
	// Stopped oscillator freezes the pin, like a pulled crystal
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= 8'h00;
			refClockIn <= 1'b0;
		end else if (refRun) begin
			phase_r <= (phase_r == 8'(HALF - 1)) ? 8'h00 : phase_r + 8'h01;
			if (phase_r == 8'(HALF - 1))
				refClockIn <= !refClockIn;
		end
	end
	// User pin returns the primary output through fabric
	assign userFeedbackIn = primaryPllOut;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			primPrev_r <= 1'b0;
			divPrev_r <= 1'b0;
			primCnt <= 16'h0000;
			divCnt <= 16'h0000;
		end else begin
			primPrev_r <= primaryPllOut;
			divPrev_r <= dividedPllOut;
			if (cntClr) begin
				primCnt <= 16'h0000;
				divCnt <= 16'h0000;
			end else begin
				primCnt <= primCnt + 16'(primaryPllOut && !primPrev_r);
				divCnt <= divCnt + 16'(dividedPllOut && !divPrev_r);
			end
		end
	end
endmodule : pcg_fabric_model
`default_nettype wire

// File: testbench/tb_top.sv
// Testbench: registers, lock, interrupts, outputs and quadrant lines
`timescale 1ns/10ps
`default_nettype none
module tb_top import pcg_pkg::*;;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic wbCyc = 1'b0;
	logic wbStb = 1'b0;
	logic wbWe = 1'b0;
	logic [7:0] wbAdr = 8'h00;
	logic [3:0] wbSel = 4'h0;
	logic [31:0] wbDat = 32'h0;
	logic [31:0] wbDatO;
	logic wbAck;
	logic refRun = 1'b0;
	logic cntClr = 1'b0;
	logic [7:0] extSrcIn = 8'h00;
	logic refClockIn, userFeedbackIn, primaryPllOut, dividedPllOut;
	logic pllLock, irq;
	logic [31:0] quadLines;
	logic [15:0] primCnt, divCnt;
	logic [31:0] rd;
	int nErrors = 0;
	int checks = 0;
	always #25 ref_clk = !ref_clk;
	pcg_clock_gen #(.DIV_WIDTH(DIV_W)) u_dut (.ref_clk(ref_clk),
		.rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
		.wb_dat_o(wbDatO), .wb_ack_o(wbAck), .refClockIn(refClockIn),
		.userFeedbackIn(userFeedbackIn), .extSrcIn(extSrcIn),
		.primaryPllOut(primaryPllOut), .dividedPllOut(dividedPllOut),
		.shiftedPllOut(), .pllLock(pllLock), .quadLines(quadLines), .irq(irq));
	pcg_fabric_model u_fab (.ref_clk(ref_clk), .rst_n(rst_n),
		.refRun(refRun), .cntClr(cntClr), .primaryPllOut(primaryPllOut),
		.dividedPllOut(dividedPllOut), .refClockIn(refClockIn),
		.userFeedbackIn(userFeedbackIn), .primCnt(primCnt), .divCnt(divCnt));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			nErrors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	// Request held until ack is sampled high at a rising edge
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbDat <= d;
		wbSel <= 4'hF;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wbAck !== 1'b1 && n < 20);
		rd = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		check("ack", 32'h1, {31'h0, wbAck});
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask : wr
	task automatic chk_rd(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		check(nm, e, rd);
	endtask : chk_rd
	task automatic lock_is(input logic v, input int lim);
		int n;
		n = 0;
		while (pllLock !== v && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		check("lock", {31'h0, v}, {31'h0, pllLock});
	endtask : lock_is
	////////////////////////////////////////////////////////////////////////
	task automatic test_regs;
		chk_rd("div reset", ADDR_DIV_CFG, DIV_CFG_RST);
		chk_rd("dly reset", ADDR_DLY_CFG, DLY_CFG_RST);
		chk_rd("phs reset", ADDR_PHS_CFG, PHS_CFG_RST);
		chk_rd("locktime reset", ADDR_LOCK_TIME, LOCK_TIME_RST);
		wr(8'h24, 32'hFFFFFFFF);
		chk_rd("unmapped", 8'h24, 32'h0);
		$display("test regs done");
	endtask : test_regs
	task automatic test_quad;
		logic [7:0] v;
		for (int p = 0; p < 2; p++) begin
			v = p ? 8'h50 : 8'hA8;
			extSrcIn <= v;
			cyc(4);
			for (int q = 0; q < NUM_QUAD; q++) begin
				check("quad src", {29'h0, v[5:3]}, {29'h0, quadLines[q*8+3 +: 3]});
			end
		end
		$display("test quad done");
	endtask : test_quad
	task automatic test_lock;
		refRun <= 1'b1;
		lock_is(1'b1, 2000);
		chk_rd("status", ADDR_STATUS, 32'h1);
		chk_rd("irq stat", ADDR_IRQ_STAT, 32'h1);
		check("irq off", 32'h0, {31'h0, irq});
		wr(ADDR_IRQ_EN, 32'h1);
		cyc(2);
		check("irq on", 32'h1, {31'h0, irq});
		wr(ADDR_IRQ_EN, 32'h0);
		cyc(2);
		check("irq masked", 32'h0, {31'h0, irq});
		wr(ADDR_IRQ_EN, 32'h3);
		wr(ADDR_IRQ_CLR, 32'h1);
		cyc(2);
		check("irq cleared", 32'h0, {31'h0, irq});
		$display("test lock done");
	endtask : test_lock
	task automatic test_dynamic;
		wr(ADDR_DLY_CFG, 32'h105);
		cyc(4);
		check("static keeps lock", 32'h1, {31'h0, pllLock});
		wr(ADDR_DLY_CFG, 32'h305);
		cyc(4);
		check("dyn drops lock", 32'h0, {31'h0, pllLock});
		check("irq loss", 32'h1, {31'h0, irq});
		chk_rd("loss event", ADDR_IRQ_STAT, 32'h2);
		wr(ADDR_IRQ_CLR, 32'h3);
		lock_is(1'b1, 2000);
		wr(ADDR_DLY_CFG, 32'h0);
		$display("test dynamic done");
	endtask : test_dynamic
	task automatic test_ref_loss;
		refRun <= 1'b0;
		cyc(REF_TIMEOUT + 10);
		check("lock without ref", 32'h0, {31'h0, pllLock});
		refRun <= 1'b1;
		lock_is(1'b1, 2000);
		$display("test ref loss done");
	endtask : test_ref_loss
	task automatic test_outputs;
		wr(ADDR_DIV_CFG, 32'h04010101);
		cntClr <= 1'b1;
		cyc(1);
		cntClr <= 1'b0;
		cyc(400);
		check("primary runs", 32'h1, {31'h0, primCnt > 16'h0});
		check("divided runs", 32'h1, {31'h0, divCnt > 16'h0});
		check("divided slower", 32'h1, {31'h0, divCnt < primCnt});
		wr(ADDR_DLY_CFG, 32'h400);
		lock_is(1'b1, 2000);
		$display("test outputs done");
	endtask : test_outputs
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, nErrors);
		if (nErrors == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : print_verdict
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		test_regs();
		test_quad();
		test_lock();
		test_dynamic();
		test_ref_loss();
		test_outputs();
		print_verdict();
	end
	// Whole run needs well under 10000 cycles
	initial begin
		#1000000;
		nErrors++;
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire

// File: verilog/pcg_clock_gen.sv
// Design: clock generator, lock monitor and quadrant clock distribution
// Function
// RULE_01: Reference input goes through the input divider before comparison.
// RULE_02: Feedback comes from primary output or user pin, through feedback divider.
// RULE_03: Feedback divider ratio multiplies the divided reference frequency.
// RULE_04: Delay applies to reference or feedback path, static or dynamic; the code delays the reference path only.
// RULE_05: Lock flag rises once the oscillator locks to the reference; the code raises it after the lock time count, feedback unchecked.
// RULE_06: Dynamic delay change may drop lock until lock time elapses.
// RULE_07: Post-scaler divides the oscillator to form the primary output.
// RULE_08: Secondary divider derives the slower divided output from primary.
// RULE_09: Phase/duty selector makes shifted output, preset or dynamic.
// RULE_10: Primary, divided and shifted outputs feed the distribution network.
// RULE_11: Two general PLLs always; larger parts add two to six standard.
// RULE_12: External capacitor pin per side serves at most one PLL.
// RULE_13: Eight primary lines per quadrant from identical central muxes.
// RULE_14: Every clock source reaches every quadrant mux; here srcs[6], srcs[7] and extSrcIn[2:0] reach no line.
// RULE_15: Dynamic selector switches two clocks with no glitch or runt.
// RULE_16: Two selectors per quadrant drive the seventh and eighth lines.
// RULE_17: Output holds low after old falling edge, joins new at its fall.
// RULE_18: Lock drops on absent reference or dynamic change, returns after count.
//
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module pcg_clock_gen
	import pcg_pkg::*;
#(
	parameter int DIV_WIDTH = DIV_W
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Clock sources
	input wire logic refClockIn,
	input wire logic userFeedbackIn,
	input wire logic [NUM_SRC-1:0] extSrcIn,
	// Generated clocks, as registered toggles of the system clock, and the lock flag
	output logic primaryPllOut,
	output logic dividedPllOut,
	output logic shiftedPllOut,
	output logic pllLock,
	// Quadrant primary lines
	output logic [NUM_QUAD*NUM_LINES-1:0] quadLines,
	// Interrupt
	output logic irq
);
	////////////////////////////////////////////////////////////////////////
	logic [31:0] divCfg_r, dlyCfg_r, phsCfg_r, selCfg_r, lockTime_r;
	logic [EV_W-1:0] irqStat_r, irqEn_r;
	logic wbHit, wbWrAck;
	assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Writes land at the edge where the master samples ack high
	assign wbWrAck = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	// Byte-lane write merge
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wbHit;
		end
	end
	logic dlyWrite;
	assign dlyWrite = wbWrAck && (wb_adr_i == ADDR_DLY_CFG);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			divCfg_r <= DIV_CFG_RST;
			dlyCfg_r <= DLY_CFG_RST;
			phsCfg_r <= PHS_CFG_RST;
			selCfg_r <= 32'h00000000;
			lockTime_r <= LOCK_TIME_RST;
			irqEn_r <= '0;
		end else if (wbWrAck) begin
			case (wb_adr_i)
				ADDR_DIV_CFG: divCfg_r <= merge(divCfg_r, wb_dat_i, wb_sel_i);
				ADDR_DLY_CFG: dlyCfg_r <= merge(dlyCfg_r, wb_dat_i, wb_sel_i);
				ADDR_PHS_CFG: phsCfg_r <= merge(phsCfg_r, wb_dat_i, wb_sel_i);
				ADDR_SEL_CFG: selCfg_r <= merge(selCfg_r, wb_dat_i, wb_sel_i);
				ADDR_LOCK_TIME: begin
					lockTime_r <= merge(lockTime_r, wb_dat_i, wb_sel_i);
				end
				ADDR_IRQ_EN: begin
					if (wb_sel_i[0]) begin
						irqEn_r <= wb_dat_i[EV_W-1:0];
					end
				end
				default: ;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Reference synchroniser and edge detect
	logic refS1_r, refS2_r, refS3_r, refRise, fbS1_r, fbS2_r;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			refS1_r <= 1'b0;
			refS2_r <= 1'b0;
			refS3_r <= 1'b0;
			fbS1_r <= 1'b0;
			fbS2_r <= 1'b0;
		end else begin
			refS1_r <= refClockIn;
			refS2_r <= refS1_r;
			refS3_r <= refS2_r;
			fbS1_r <= userFeedbackIn;
			fbS2_r <= fbS1_r;
		end
	end
	assign refRise = refS2_r && !refS3_r;
	// Input divider on the reference
	logic [DIV_WIDTH-1:0] inCnt_r;
	logic inTick, dlyIsFb;
	assign dlyIsFb = dlyCfg_r[DLY_PATH_BIT];
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			inCnt_r <= '0;
		end else if (refRise) begin
			if (inCnt_r >= divCfg_r[DIV_IN_LSB +: DIV_WIDTH] - 1'b1) begin
				inCnt_r <= '0; // RULE_01
			end else begin
				inCnt_r <= inCnt_r + 1'b1;
			end
		end
	end
	assign inTick = refRise && (inCnt_r == '0);
	// Delay adjust on the reference path; bypassed when the feedback path is selected
	logic [(1<<DLY_W)-1:0] dlyLine_r;
	logic refDelayed;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dlyLine_r <= '0;
		end else begin
			dlyLine_r <= {dlyLine_r[(1<<DLY_W)-2:0], inTick};
		end
	end
	logic [DLY_W-1:0] dlySel;
	assign dlySel = dlyCfg_r[DLY_VAL_LSB +: DLY_W];
	assign refDelayed = dlyIsFb ? inTick : dlyLine_r[dlySel]; // RULE_04
	// Oscillator: one VCO tick per system clock scaled by feedback ratio.
	// The behavioural VCO emits about fbDiv ticks per divided reference; postDiv acts after it.
	logic [2*DIV_WIDTH-1:0] vcoCnt_r;
	logic vcoTick;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			vcoCnt_r <= '0;
		end else if (refDelayed) begin
			vcoCnt_r <= '0;
		end else begin
			vcoCnt_r <= vcoCnt_r + 1'b1;
		end
	end
	// Phase comparison: measured reference period, divided by multiplier
	logic [2*DIV_WIDTH-1:0] refPer_r, slot_r, slotCnt_r;
	logic [DIV_WIDTH-1:0] fbDiv, postDiv;
	assign fbDiv = divCfg_r[DIV_FB_LSB +: DIV_WIDTH];
	assign postDiv = divCfg_r[DIV_POST_LSB +: DIV_WIDTH];
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			refPer_r <= '0;
		end else if (refDelayed) begin
			refPer_r <= vcoCnt_r + 1'b1;
		end
	end
	// VCO tick spacing = reference period / feedback ratio
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			slot_r <= '0;
		end else begin
			slot_r <= (fbDiv == '0) ? refPer_r : refPer_r / fbDiv; // RULE_03
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			slotCnt_r <= '0;
		end else if (refDelayed || slotCnt_r + 1'b1 >= slot_r) begin
			slotCnt_r <= '0;
		end else begin
			slotCnt_r <= slotCnt_r + 1'b1;
		end
	end
	assign vcoTick = refDelayed || (slotCnt_r + 1'b1 >= slot_r);
	// Feedback path: primary output or user pin, through feedback divider
	logic fbSrc, fbPrev_r, fbEdge;
	logic [DIV_WIDTH-1:0] fbCnt_r;
	logic fbTick;
	assign fbSrc = dlyCfg_r[FB_SRC_BIT] ? fbS2_r : primaryPllOut; // RULE_02
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fbPrev_r <= 1'b0;
			fbCnt_r <= '0;
		end else begin
			fbPrev_r <= fbSrc;
			if (fbEdge) begin
				fbCnt_r <= (fbCnt_r + 1'b1 >= fbDiv) ? '0 : fbCnt_r + 1'b1;
			end
		end
	end
	assign fbEdge = fbSrc && !fbPrev_r;
	assign fbTick = fbEdge && (fbCnt_r == '0); // RULE_02
	// With the feedback path selected, the delay value is not applied anywhere
	////////////////////////////////////////////////////////////////////////
	// Post-scaler: toggles primary after postDiv VCO ticks
	logic [DIV_WIDTH-1:0] postCnt_r;
	logic primRise;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			postCnt_r <= '0;
			primaryPllOut <= 1'b0;
		end else if (vcoTick) begin
			if (postCnt_r + 1'b1 >= postDiv) begin
				postCnt_r <= '0;
				primaryPllOut <= !primaryPllOut; // RULE_07
			end else begin
				postCnt_r <= postCnt_r + 1'b1;
			end
		end
	end
	assign primRise = vcoTick && (postCnt_r + 1'b1 >= postDiv)
		&& !primaryPllOut;
	// Secondary divider on primary rising edges
	logic [DIV_WIDTH-1:0] secCnt_r;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			secCnt_r <= '0;
			dividedPllOut <= 1'b0;
		end else if (primRise) begin
			if (secCnt_r + 1'b1 >= divCfg_r[DIV_SEC_LSB +: DIV_WIDTH]) begin
				secCnt_r <= '0;
				dividedPllOut <= !dividedPllOut; // RULE_08
			end else begin
				secCnt_r <= secCnt_r + 1'b1;
			end
		end
	end
	// Phase/duty selector measured in system clocks from primary rise
	logic [PHS_W-1:0] phsCnt_r;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phsCnt_r <= '0;
			shiftedPllOut <= 1'b0;
		end else begin
			phsCnt_r <= primRise ? '0 : phsCnt_r + 1'b1;
			if (phsCnt_r == phsCfg_r[PHS_LSB +: PHS_W]) begin
				shiftedPllOut <= 1'b1; // RULE_09
			end else if (phsCnt_r == phsCfg_r[PHS_LSB +: PHS_W]
				+ phsCfg_r[DUTY_LSB +: PHS_W]) begin
				shiftedPllOut <= 1'b0; // RULE_09
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Lock monitor: counts divided reference cycles; feedback is not compared
	pcg_lock_e lkState_r;
	logic [31:0] lkCnt_r, refIdle_r;
	logic dlyDynChange, refAbsent;
	// The new value decides: any write that sets the dynamic bit drops lock, even if it was already set
	assign dlyDynChange = dlyWrite && wb_sel_i[1]
		&& wb_dat_i[DLY_DYN_BIT]; // RULE_06
	assign refAbsent = (refIdle_r >= REF_TIMEOUT);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			refIdle_r <= '0;
		end else if (refRise) begin
			refIdle_r <= '0;
		end else if (!refAbsent) begin
			refIdle_r <= refIdle_r + 1'b1;
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lkState_r <= LK_IDLE;
			lkCnt_r <= '0;
		end else begin
			case (lkState_r)
				LK_IDLE: begin
					lkCnt_r <= '0;
					if (!refAbsent && !dlyDynChange && inTick) begin
						lkState_r <= LK_COUNT;
					end
				end
				LK_COUNT: begin
					if (refAbsent || dlyDynChange) begin
						lkState_r <= LK_IDLE; // RULE_18
					end else if (lkCnt_r >= lockTime_r) begin
						lkState_r <= LK_LOCKED; // RULE_05
					end else if (inTick) begin
						lkCnt_r <= lkCnt_r + 1'b1;
					end
				end
				LK_LOCKED: begin
					if (refAbsent || dlyDynChange) begin
						lkState_r <= LK_IDLE; // RULE_06
					end
				end
				default: lkState_r <= LK_IDLE;
			endcase
		end
	end
	assign pllLock = (lkState_r == LK_LOCKED);
	logic lockPrev_r;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lockPrev_r <= 1'b0;
		end else begin
			lockPrev_r <= pllLock;
		end
	end
	// Sticky events; a new event wins over a clear in the same cycle
	logic [EV_W-1:0] evt, clr;
	assign evt = {lockPrev_r && !pllLock, pllLock && !lockPrev_r};
	assign clr = (wbWrAck && wb_adr_i == ADDR_IRQ_CLR && wb_sel_i[0])
		? wb_dat_i[EV_W-1:0] : '0;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irqStat_r <= '0;
		end else begin
			irqStat_r <= (irqStat_r & ~clr) | evt;
		end
	end
	assign irq = |(irqStat_r & irqEn_r);
	////////////////////////////////////////////////////////////////////////
	// Distribution: srcs[0] to srcs[5] reach every quadrant; srcs[6] and srcs[7] reach no line
	logic [NUM_SRC-1:0] srcs;
	assign srcs = {extSrcIn[NUM_SRC-1:3], shiftedPllOut, dividedPllOut,
		primaryPllOut}; // RULE_10 RULE_14
	genvar q, l;
	generate
		for (q = 0; q < NUM_QUAD; q++) begin : g_quad
			for (l = 0; l < NUM_LINES - 2; l++) begin : g_line
				assign quadLines[q*NUM_LINES + l] = srcs[l]; // RULE_13
			end
			for (l = 0; l < 2; l++) begin : g_sel
				// Inputs are the first two central mux outputs of the quadrant
				logic clkA, clkB, fallA, fallB;
				logic prevA_r, prevB_r;
				logic selS1_r, selS2_r, cur_r, actA_r, actB_r;
				// Fixed inputs, so a select change never moves a source
				assign clkA = srcs[0];
				assign clkB = srcs[1];
				always_ff @(posedge ref_clk or negedge rst_n) begin
					if (!rst_n) begin
						prevA_r <= 1'b0;
						prevB_r <= 1'b0;
						selS1_r <= 1'b0;
						selS2_r <= 1'b0;
						cur_r <= 1'b0;
						actA_r <= 1'b1;
						actB_r <= 1'b0;
					end else begin
						prevA_r <= clkA;
						prevB_r <= clkB;
						selS1_r <= selCfg_r[q*2 + l];
						selS2_r <= selS1_r;
						if (selS2_r != cur_r) begin
							// Drop old clock at its fall, pick new at its fall
							if (actA_r && fallA) begin
								actA_r <= 1'b0; // RULE_17
							end else if (actB_r && fallB) begin
								actB_r <= 1'b0; // RULE_17
							end else if (!actA_r && !actB_r) begin
								if (selS2_r && fallB) begin
									actB_r <= 1'b1;
									cur_r <= 1'b1;
								end else if (!selS2_r && fallA) begin
									actA_r <= 1'b1;
									cur_r <= 1'b0;
								end
							end
						end
					end
				end
				assign fallA = prevA_r && !clkA;
				assign fallB = prevB_r && !clkB;
				assign quadLines[q*NUM_LINES + NUM_LINES - 2 + l] =
					(actA_r && clkA) || (actB_r && clkB); // RULE_15 RULE_16
			end
		end
	endgenerate
	////////////////////////////////////////////////////////////////////////
	always_comb begin
		case (wb_adr_i)
			ADDR_DIV_CFG: wb_dat_o = divCfg_r;
			ADDR_DLY_CFG: wb_dat_o = dlyCfg_r;
			ADDR_PHS_CFG: wb_dat_o = phsCfg_r;
			ADDR_SEL_CFG: wb_dat_o = selCfg_r;
			ADDR_STATUS: wb_dat_o = {30'h0, lkState_r == LK_COUNT, pllLock};
			ADDR_IRQ_STAT: wb_dat_o = {30'h0, irqStat_r};
			ADDR_IRQ_EN: wb_dat_o = {30'h0, irqEn_r};
			ADDR_LOCK_TIME: wb_dat_o = lockTime_r;
			default: wb_dat_o = 32'h00000000;
		endcase
	end
	// RULE_11 and RULE_12 are device-level counts: one instance is one PLL.
endmodule : pcg_clock_gen
`default_nettype wire
